// ### hdl/ilc_change_detect.sv
`timescale 1ns/1ps
module ilc_change_detect
  import ilc_pkg::*;
#(
  parameter int LINES = LINE_COUNT
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             reset_n,   // Synchronous reset, low
  input  wire logic [LINES-1:0] padIn,     // Raw pad levels
  output logic      [LINES-1:0] padLevel,  // Synchronised levels
  output logic      [LINES-1:0] change     // One-cycle change flags
);
  import ilc_pkg::*;

  typedef struct packed {
    logic [LINES-1:0]       meta;
    logic [LINES-1:0]       sync;
    logic [LINES-1:0]       prev;
    logic [SYNC_WARMUP-1:0] warm;
  } ilc_sync_t;

  ilc_sync_t s_q;
  ilc_sync_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = padIn;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.warm = {s_q.warm[SYNC_WARMUP-2:0], 1'b1};
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Warm-up hides the false edge of reset zeros meeting real levels
  assign padLevel = s_q.sync;
  assign change   = s_q.warm[SYNC_WARMUP-1] ? (s_q.sync ^ s_q.prev) : '0;  // see RL18

endmodule

// ### hdl/ilc_pkg.sv
package ilc_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int LINE_COUNT = 32;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 32;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_LEVEL_STATE = 32'h400E_0E38;
  localparam logic [ADDR_W-1:0] ADDR_PAD_LEVEL_STATE    = 32'h400E_0E3C;
  localparam logic [ADDR_W-1:0] ADDR_CHANGE_IRQ_ENABLE  = 32'h400E_0E40;
  localparam logic [ADDR_W-1:0] ADDR_CHANGE_IRQ_DISABLE = 32'h400E_0E44;
  localparam logic [ADDR_W-1:0] ADDR_CHANGE_IRQ_MASK    = 32'h400E_0E48;
  localparam logic [ADDR_W-1:0] ADDR_CHANGE_IRQ_STATE   = 32'h400E_0E4C;
  localparam logic [ADDR_W-1:0] ADDR_OPEN_DRAIN_ENABLE  = 32'h400E_0E50;
  localparam logic [ADDR_W-1:0] ADDR_OPEN_DRAIN_DISABLE = 32'h400E_0E54;
  localparam logic [ADDR_W-1:0] ADDR_OPEN_DRAIN_STATE   = 32'h400E_0E58;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_DISABLE     = 32'h400E_0E60;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_ENABLE      = 32'h400E_0E64;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_STATE       = 32'h400E_0E68;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CONTROL       = 32'h400E_0EE4;

  // ****************************************************************
  // Port control fields
  // ****************************************************************
  localparam int CTRL_WRITE_PROTECT_BIT = 0;
  localparam int CTRL_DIRECT_WRITE_BIT  = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_OUTPUT_LEVEL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_IRQ_MASK     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_IRQ_STATE    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_OPEN_DRAIN   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_PULLUP_ON    = 32'hFFFF_FFFF;
  localparam logic              RST_WRITE_PROT   = 1'b0;
  localparam logic              RST_DIRECT_WRITE = 1'b0;

  // ****************************************************************
  // Bus responses and input sampling
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         SYNC_WARMUP = 3;

endpackage

// ### hdl/ilc_port_ctrl.sv
`timescale 1ns/1ps
// How it works
// RL1 - Output level register reads the level each line is set to drive.
// RL2 - Output level always readable; direct writes only when control bit allows.
// RL3 - Pad level register reads the sampled level of each line.
// RL4 - Writing one to irq enable turns on that line's change interrupt.
// RL5 - Writing one to irq disable turns off that line's change interrupt.
// RL6 - Irq mask register shows which lines have change interrupt enabled.
// RL7 - A detected change sets the line's irq state bit until read.
// RL8 - Reading irq state or reset clears it; new change needed to set.
// RL9 - Open-drain and pull-up writes ignored while write protect is set.
// RL10 - Writing one to open-drain enable makes that line open-drain.
// RL11 - Writing one to open-drain disable returns that line to push-pull.
// RL12 - Open-drain line drives only low; high releases the line.
// RL13 - Push-pull line drives both levels; open-drain state reads zero.
// RL14 - Writing one to pull-up disable turns that line's pull-up off.
// RL15 - Writing one to pull-up enable turns that line's pull-up on.
// RL16 - Pull-up state bit reads zero when enabled, one when disabled.
// RL17 - Interrupt output high while any line has state and mask set.
// RL18 - Change is synchronised level differing from previous cycle's level.
module ilc_port_ctrl
  import ilc_pkg::*;
#(
  parameter int LINES = LINE_COUNT
) (
  input  wire logic                 clk_sys,        // System clock
  input  wire logic                 reset_n,        // Synchronous reset, low
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,   // Write address
  input  wire logic                 s_axi_awvalid,  // Write address valid
  output logic                      s_axi_awready,  // Write address ready
  input  wire logic [DATA_W-1:0]    s_axi_wdata,    // Write data
  input  wire logic [DATA_W/8-1:0]  s_axi_wstrb,    // Write byte strobes
  input  wire logic                 s_axi_wvalid,   // Write data valid
  output logic                      s_axi_wready,   // Write data ready
  output logic [1:0]                s_axi_bresp,    // Write response
  output logic                      s_axi_bvalid,   // Write response valid
  input  wire logic                 s_axi_bready,   // Write response ready
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,   // Read address
  input  wire logic                 s_axi_arvalid,  // Read address valid
  output logic                      s_axi_arready,  // Read address ready
  output logic [DATA_W-1:0]         s_axi_rdata,    // Read data
  output logic [1:0]                s_axi_rresp,    // Read response
  output logic                      s_axi_rvalid,   // Read data valid
  input  wire logic                 s_axi_rready,   // Read data ready
  input  wire logic [LINES-1:0]     padIn,          // Pad input levels
  output logic [LINES-1:0]          padOut,         // Pad output levels
  output logic [LINES-1:0]          padOeN,         // Pad drive enable, low
  output logic [LINES-1:0]          pullupEn,       // Pull-up resistor on
  output logic                      irq             // Change interrupt
);
  import ilc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic              awRdy;
    logic              awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic              wRdy;
    logic              wHeld;
    logic [DATA_W-1:0] wData;
    logic [DATA_W-1:0] wMask;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arRdy;
    logic              rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0]        rResp;
    logic [LINES-1:0]  outLevel;
    logic [LINES-1:0]  irqMask;
    logic [LINES-1:0]  irqState;
    logic [LINES-1:0]  openDrain;
    logic [LINES-1:0]  pullupOn;
    logic              writeProt;
    logic              directWr;
    logic [LINES-1:0]  padOut;
    logic [LINES-1:0]  padOeN;
    logic [LINES-1:0]  pullupEn;
    logic              irq;
  } ilc_state_t;

  ilc_state_t r_q;
  ilc_state_t r_d;

  logic [LINES-1:0] padLevel;
  logic [LINES-1:0] change;
  logic             wrFire;
  logic             rdFire;
  logic [LINES-1:0] wrBits;

  ilc_change_detect #(
    .LINES    (LINES)
  ) u_detect (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .padIn    (padIn),
    .padLevel (padLevel),
    .change   (change)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [DATA_W-1:0] strbMask(input logic [DATA_W/8-1:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W/8; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Write-one-to-set or write-one-to-clear on a per-line bit vector
  function automatic logic [LINES-1:0] setClr(input logic [LINES-1:0] cur,
                                              input logic [LINES-1:0] bits,
                                              input logic             on);
    return on ? (cur | bits) : (cur & ~bits);
  endfunction

  // A write fires once address and data are both held and no response waits
  assign wrFire = r_q.awHeld && r_q.wHeld && !r_q.bValid;
  assign rdFire = s_axi_arvalid && r_q.arRdy;
  assign wrBits = r_q.wData[LINES-1:0] & r_q.wMask[LINES-1:0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_d = r_q;

    if (s_axi_awvalid && r_q.awRdy) begin
      r_d.awHeld = 1'b1;
      r_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_q.wRdy) begin
      r_d.wHeld = 1'b1;
      r_d.wData = s_axi_wdata;
      r_d.wMask = strbMask(s_axi_wstrb);
    end
    if (r_q.bValid && s_axi_bready) begin
      r_d.bValid = 1'b0;
    end
    if (r_q.rValid && s_axi_rready) begin
      r_d.rValid = 1'b0;
    end

    // Change flags are folded in first; a state read below reloads them so a set in the clearing cycle wins
    r_d.irqState = r_q.irqState | change;  // see RL7

    if (wrFire) begin
      r_d.awHeld = 1'b0;
      r_d.wHeld  = 1'b0;
      r_d.bValid = 1'b1;
      r_d.bResp  = RESP_OKAY;
      unique case (r_q.awAddr)
        ADDR_OUTPUT_LEVEL_STATE: begin
          if (r_q.directWr) begin  // see RL2
            r_d.outLevel = (r_q.outLevel & ~r_q.wMask[LINES-1:0]) | wrBits;
          end
        end
        ADDR_CHANGE_IRQ_ENABLE: r_d.irqMask = setClr(r_q.irqMask, wrBits, 1'b1);  // see RL4
        ADDR_CHANGE_IRQ_DISABLE: r_d.irqMask = setClr(r_q.irqMask, wrBits, 1'b0);  // see RL5
        ADDR_OPEN_DRAIN_ENABLE: begin
          if (!r_q.writeProt) begin  // see RL9
            r_d.openDrain = setClr(r_q.openDrain, wrBits, 1'b1);  // see RL10
          end
        end
        ADDR_OPEN_DRAIN_DISABLE: begin
          if (!r_q.writeProt) begin  // see RL9
            r_d.openDrain = setClr(r_q.openDrain, wrBits, 1'b0);  // see RL11
          end
        end
        ADDR_PULLUP_DISABLE: begin
          if (!r_q.writeProt) begin  // see RL9
            r_d.pullupOn = setClr(r_q.pullupOn, wrBits, 1'b0);  // see RL14
          end
        end
        ADDR_PULLUP_ENABLE: begin
          if (!r_q.writeProt) begin  // see RL9
            r_d.pullupOn = setClr(r_q.pullupOn, wrBits, 1'b1);  // see RL15
          end
        end
        ADDR_PORT_CONTROL: begin
          if (r_q.wMask[0]) begin
            r_d.writeProt = r_q.wData[CTRL_WRITE_PROTECT_BIT];
            r_d.directWr  = r_q.wData[CTRL_DIRECT_WRITE_BIT];
          end
        end
        // Read-only registers swallow writes quietly
        ADDR_PAD_LEVEL_STATE, ADDR_CHANGE_IRQ_MASK, ADDR_CHANGE_IRQ_STATE,
        ADDR_OPEN_DRAIN_STATE, ADDR_PULLUP_STATE: ;
        default: r_d.bResp = RESP_SLVERR;
      endcase
    end

    if (rdFire) begin
      r_d.rValid = 1'b1;
      r_d.rResp  = RESP_OKAY;
      r_d.rData  = '0;
      unique case (s_axi_araddr)
        ADDR_OUTPUT_LEVEL_STATE: r_d.rData[LINES-1:0] = r_q.outLevel;  // see RL1
        ADDR_PAD_LEVEL_STATE: r_d.rData[LINES-1:0] = padLevel;  // see RL3
        ADDR_CHANGE_IRQ_MASK: r_d.rData[LINES-1:0] = r_q.irqMask;  // see RL6
        ADDR_CHANGE_IRQ_STATE: begin
          r_d.rData[LINES-1:0] = r_q.irqState;
          r_d.irqState         = change;  // see RL8
        end
        ADDR_OPEN_DRAIN_STATE: r_d.rData[LINES-1:0] = r_q.openDrain;  // see RL13
        ADDR_PULLUP_STATE: r_d.rData[LINES-1:0] = ~r_q.pullupOn;  // see RL16
        ADDR_PORT_CONTROL: begin
          r_d.rData[CTRL_WRITE_PROTECT_BIT] = r_q.writeProt;
          r_d.rData[CTRL_DIRECT_WRITE_BIT]  = r_q.directWr;
        end
        ADDR_CHANGE_IRQ_ENABLE, ADDR_CHANGE_IRQ_DISABLE, ADDR_OPEN_DRAIN_ENABLE,
        ADDR_OPEN_DRAIN_DISABLE, ADDR_PULLUP_DISABLE, ADDR_PULLUP_ENABLE: ;
        default: r_d.rResp = RESP_SLVERR;
      endcase
    end

    // One write and one read in flight; ready drops while busy
    r_d.awRdy = !r_d.awHeld && !r_d.bValid;
    r_d.wRdy  = !r_d.wHeld && !r_d.bValid;
    r_d.arRdy = !r_d.rValid;

    // Open-drain high releases the pad instead of driving it
    r_d.padOut   = r_d.outLevel;
    r_d.padOeN   = r_d.openDrain & r_d.outLevel;  // see RL12, RL13
    r_d.pullupEn = r_d.pullupOn;
    r_d.irq      = |(r_d.irqState & r_d.irqMask);  // see RL17
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      r_q           <= '0;
      r_q.awRdy     <= 1'b1;
      r_q.wRdy      <= 1'b1;
      r_q.arRdy     <= 1'b1;
      r_q.outLevel  <= RST_OUTPUT_LEVEL;
      r_q.irqMask   <= RST_IRQ_MASK;
      r_q.irqState  <= RST_IRQ_STATE;  // see RL8
      r_q.openDrain <= RST_OPEN_DRAIN;
      r_q.pullupOn  <= RST_PULLUP_ON;
      r_q.writeProt <= RST_WRITE_PROT;
      r_q.directWr  <= RST_DIRECT_WRITE;
      r_q.padOut    <= RST_OUTPUT_LEVEL;
      r_q.padOeN    <= RST_OPEN_DRAIN & RST_OUTPUT_LEVEL;
      r_q.pullupEn  <= RST_PULLUP_ON;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = r_q.awRdy;
  assign s_axi_wready  = r_q.wRdy;
  assign s_axi_bvalid  = r_q.bValid;
  assign s_axi_bresp   = r_q.bResp;
  assign s_axi_arready = r_q.arRdy;
  assign s_axi_rvalid  = r_q.rValid;
  assign s_axi_rdata   = r_q.rData;
  assign s_axi_rresp   = r_q.rResp;
  assign padOut        = r_q.padOut;
  assign padOeN        = r_q.padOeN;
  assign pullupEn      = r_q.pullupEn;
  assign irq           = r_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_out_level_read: assert property (  // see RL1
    rdFire && s_axi_araddr == ADDR_OUTPUT_LEVEL_STATE |=> s_axi_rvalid
      && s_axi_rdata[LINES-1:0] == $past(r_q.outLevel))
    else $error("output level read wrong");

  chk_direct_write_gate: assert property (  // see RL2
    wrFire && r_q.awAddr == ADDR_OUTPUT_LEVEL_STATE && !r_q.directWr
      |=> $stable(r_q.outLevel))
    else $error("output level written while locked");

  chk_pad_level_read: assert property (  // see RL3
    rdFire && s_axi_araddr == ADDR_PAD_LEVEL_STATE
      |=> s_axi_rdata[LINES-1:0] == $past(padLevel))
    else $error("pad level read wrong");

  chk_irq_enable_set: assert property (  // see RL4
    wrFire && r_q.awAddr == ADDR_CHANGE_IRQ_ENABLE
      |=> r_q.irqMask == ($past(r_q.irqMask) | $past(wrBits)))
    else $error("irq enable did not set mask");

  chk_irq_disable_clr: assert property (  // see RL5
    wrFire && r_q.awAddr == ADDR_CHANGE_IRQ_DISABLE
      |=> r_q.irqMask == ($past(r_q.irqMask) & ~$past(wrBits)))
    else $error("irq disable did not clear mask");

  chk_change_sticky: assert property (  // see RL7
    |change |=> (r_q.irqState & $past(change)) == $past(change))
    else $error("change not latched");

  chk_state_read_clear: assert property (  // see RL8
    rdFire && s_axi_araddr == ADDR_CHANGE_IRQ_STATE
      |=> r_q.irqState == $past(change) && s_axi_rvalid)
    else $error("irq state not cleared by read");

  chk_protect_blocks: assert property (  // see RL9
    wrFire && r_q.writeProt |=> $stable(r_q.openDrain) && $stable(r_q.pullupOn))
    else $error("protected register changed");

  chk_open_drain_pad: assert property (  // see RL12
    padOeN == (r_q.openDrain & padOut))
    else $error("open-drain drive wrong");

  chk_irq_output: assert property (  // see RL17
    irq == |(r_q.irqState & r_q.irqMask))
    else $error("irq output wrong");

  chk_mask_read_back: assert property (  // see RL6
    rdFire && s_axi_araddr == ADDR_CHANGE_IRQ_MASK
      |=> s_axi_rdata[LINES-1:0] == $past(r_q.irqMask))
    else $error("irq mask read wrong");

  chk_open_drain_set: assert property (  // see RL10
    wrFire && r_q.awAddr == ADDR_OPEN_DRAIN_ENABLE && !r_q.writeProt
      |=> r_q.openDrain == ($past(r_q.openDrain) | $past(wrBits)))
    else $error("open-drain enable did not set");

  chk_open_drain_clr: assert property (  // see RL11
    wrFire && r_q.awAddr == ADDR_OPEN_DRAIN_DISABLE && !r_q.writeProt
      |=> r_q.openDrain == ($past(r_q.openDrain) & ~$past(wrBits)))
    else $error("open-drain disable did not clear");

  chk_push_pull_drive: assert property (  // see RL13
    ((padOeN & ~r_q.openDrain) == '0) && (padOut == r_q.outLevel))
    else $error("push-pull line not driven");

  chk_pullup_state_read: assert property (  // see RL16
    rdFire && s_axi_araddr == ADDR_PULLUP_STATE
      |=> s_axi_rdata[LINES-1:0] == ~$past(pullupEn))
    else $error("pull-up state read wrong");

endmodule

// ### testbench/ilc_pad_model.sv
`timescale 1ns/1ps
module ilc_pad_model
  import ilc_pkg::*;
(
  input  wire logic                  clk_sys,   // System clock
  input  wire logic [LINE_COUNT-1:0] padOut,    // Device drive level
  input  wire logic [LINE_COUNT-1:0] padOeN,    // Device drive enable, low
  input  wire logic [LINE_COUNT-1:0] pullupEn,  // Device pull-up on
  input  wire logic [LINE_COUNT-1:0] extEn,     // Board device drives extVal
  input  wire logic [LINE_COUNT-1:0] extVal,    // Board drive level
  output logic      [LINE_COUNT-1:0] padLine    // Resolved pad level
);
  // ****************************************************************
  // Wired pad resolution
  // ****************************************************************
  logic [LINE_COUNT-1:0] lastQ = '0;

  always_ff @(posedge clk_sys) begin
    lastQ <= padLine;
  end

  // Floating line flips every cycle so a stale value never passes
  always_comb begin
    for (int i = 0; i < LINE_COUNT; i++) begin
      if (!padOeN[i] || extEn[i]) begin
        padLine[i] = (padOeN[i] | padOut[i]) & (!extEn[i] | extVal[i]);
      end else if (pullupEn[i]) begin
        padLine[i] = 1'b1;
      end else begin
        padLine[i] = ~lastQ[i];
      end
    end
  end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin badCount++; \
  $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top
  import ilc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] padIn, padOut, padOeN, pullupEn, extEn, extVal;
  int          badCount = 0;
  int          compares = 0;

  always #5 clk_sys = ~clk_sys;

  ilc_port_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .padIn(padIn),
    .padOut(padOut), .padOeN(padOeN), .pullupEn(pullupEn), .irq(irq));

  ilc_pad_model pads (.clk_sys(clk_sys), .padOut(padOut), .padOeN(padOeN),
    .pullupEn(pullupEn), .extEn(extEn), .extVal(extVal), .padLine(padIn));

  // ****************************************************************
  // Expectations and bus tasks
  // ****************************************************************
  function automatic logic [31:0] expOeN(input logic [31:0] od, input logic [31:0] lvl);
    return od & lvl;
  endfunction

  function automatic logic expIrq(input logic [31:0] st, input logic [31:0] msk);
    return |(st & msk);
  endfunction

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 60) begin
      badCount++;
      $display("BAD %0t bus timeout", $time);
      summarize();
    end
  endtask

  // Bready and rready stay high, so every answer is taken at once
  task automatic busWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int n;
    n = 0;
    rsp = 2'h3;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) rsp = s_axi_bresp;
    end while (!s_axi_bvalid && n < 60);
    hang(n);
  endtask

  task automatic busRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rsp);
    int n;
    n = 0;
    rsp = 2'h3;
    d = 32'h0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rsp = s_axi_rresp;
        d = s_axi_rdata;
      end
    end while (!s_axi_rvalid && n < 60);
    hang(n);
  endtask

  task automatic wrOk(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    busWrite(a, d, r);
    `CHK(r, RESP_OKAY)
  endtask

  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    busRead(a, d, r);
    `CHK(r, RESP_OKAY)
    `CHK(d, e)
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] rv, e, m, o, v, p;
    logic [1:0]  rs;
    rv = $urandom(32'h5FEA);
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    extEn = 32'h0;
    extVal = 32'h0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdChk(ADDR_CHANGE_IRQ_MASK, RST_IRQ_MASK);
    rdChk(ADDR_CHANGE_IRQ_STATE, 32'h0);
    rdChk(ADDR_OPEN_DRAIN_STATE, 32'h0);
    rdChk(ADDR_PULLUP_STATE, 32'h0);
    rdChk(ADDR_PAD_LEVEL_STATE, 32'h0);
    busRead(ADDR_PULLUP_STATE + 32'h4, rv, rs);
    `CHK({rs, rv}, {RESP_SLVERR, 32'h0})
    busWrite(ADDR_PULLUP_STATE + 32'h4, 32'h1, rs);
    `CHK(rs, RESP_SLVERR)
    v = $urandom();
    wrOk(ADDR_OUTPUT_LEVEL_STATE, v | 32'h1);
    rdChk(ADDR_OUTPUT_LEVEL_STATE, 32'h0);
    $display("test reset_and_map done");
    wrOk(ADDR_PORT_CONTROL, 32'h2);
    for (int k = 0; k < 4; k++) begin
      o = (k == 0) ? 32'hFFFF_FFFF : $urandom();
      v = (k == 1) ? 32'h0 : $urandom();
      wrOk(ADDR_OPEN_DRAIN_DISABLE, 32'hFFFF_FFFF);
      wrOk(ADDR_OPEN_DRAIN_ENABLE, o);
      wrOk(ADDR_OPEN_DRAIN_STATE, ~o);
      rdChk(ADDR_OPEN_DRAIN_STATE, o);
      wrOk(ADDR_OUTPUT_LEVEL_STATE, v);
      rdChk(ADDR_OUTPUT_LEVEL_STATE, v);
      `CHK(padOut, v)
      `CHK(padOeN, expOeN(o, v))
      repeat (4) @(posedge clk_sys);
      rdChk(ADDR_PAD_LEVEL_STATE, v);
      p = $urandom();
      wrOk(ADDR_OPEN_DRAIN_DISABLE, p);
      rdChk(ADDR_OPEN_DRAIN_STATE, o & ~p);
      `CHK(padOeN, expOeN(o & ~p, v))
    end
    $display("test open_drain done");
    wrOk(ADDR_PORT_CONTROL, 32'h3);
    rdChk(ADDR_PORT_CONTROL, 32'h3);
    wrOk(ADDR_OPEN_DRAIN_DISABLE, 32'hFFFF_FFFF);
    wrOk(ADDR_OPEN_DRAIN_ENABLE, ~(o & ~p));
    wrOk(ADDR_PULLUP_DISABLE, 32'hFFFF_FFFF);
    rdChk(ADDR_OPEN_DRAIN_STATE, o & ~p);
    rdChk(ADDR_PULLUP_STATE, 32'h0);
    wrOk(ADDR_PORT_CONTROL, 32'h2);
    p = $urandom();
    e = $urandom();
    wrOk(ADDR_PULLUP_DISABLE, p);
    rdChk(ADDR_PULLUP_STATE, p);
    `CHK(pullupEn, ~p)
    wrOk(ADDR_PULLUP_ENABLE, e);
    rdChk(ADDR_PULLUP_STATE, p & ~e);
    `CHK(pullupEn, ~(p & ~e))
    wrOk(ADDR_PULLUP_ENABLE, 32'hFFFF_FFFF);
    $display("test protect_and_pullup done");
    wrOk(ADDR_OPEN_DRAIN_ENABLE, 32'hFFFF_FFFF);
    wrOk(ADDR_OUTPUT_LEVEL_STATE, 32'hFFFF_FFFF);
    for (int r = 0; r < 3; r++) begin
      e = $urandom() | 32'h8000_0001;
      m = (r == 0) ? e : $urandom();
      wrOk(ADDR_CHANGE_IRQ_DISABLE, 32'hFFFF_FFFF);
      wrOk(ADDR_CHANGE_IRQ_ENABLE, m);
      rdChk(ADDR_CHANGE_IRQ_MASK, m);
      repeat (6) @(posedge clk_sys);
      busRead(ADDR_CHANGE_IRQ_STATE, rv, rs);
      extEn <= e;
      repeat (6) @(posedge clk_sys);
      `CHK(irq, expIrq(e, m))
      rdChk(ADDR_CHANGE_IRQ_STATE, e);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 1'b0)
      rdChk(ADDR_CHANGE_IRQ_STATE, 32'h0);
      extEn <= 32'h0;
      repeat (6) @(posedge clk_sys);
      rdChk(ADDR_CHANGE_IRQ_STATE, e);
    end
    $display("test change_irq done");
    summarize();
  end
endmodule
